// file: adc_ctrl_pkg.sv
// Package with register map, field positions and encodings for the converter control block
package adc_ctrl_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_MAIN_CONTROL   = 4'h0;
   localparam logic [3:0] OFS_CLOCK_INPUT    = 4'h1;
   localparam logic [3:0] OFS_REF_GAIN       = 4'h2;
   localparam logic [3:0] OFS_RESULT_HIGH    = 4'h3;
   localparam logic [3:0] OFS_RESULT_LOW     = 4'h4;
   localparam logic [3:0] OFS_PIN_FUNCTION   = 4'h5;
   localparam logic [3:0] OFS_IRQ_FLAG       = 4'h6;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MAIN_START_BIT   = 7;
   localparam int MAIN_BUSY_BIT    = 6;
   localparam int MAIN_POWER_BIT   = 5;
   localparam int MAIN_ALIGN_BIT   = 4;
   localparam int REF_PGA_EN_BIT   = 7;
   localparam int REF_PGA_IS_BIT   = 4;
   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MAIN_WRITE_MASK  = 8'hBF;
   localparam logic [7:0] CLKIN_WRITE_MASK = 8'hF7;
   localparam logic [7:0] REF_WRITE_MASK   = 8'hBF;
   localparam logic [7:0] RESET_BYTE       = 8'h00;
   // ----------------------------------------------------------------
   // Timing counts in converter clock cycles, and the system clock period in ns
   // ----------------------------------------------------------------
   localparam int SAMPLE_CYCLES   = 4;
   localparam int CONVERT_CYCLES  = 12;
   localparam int TOTAL_CYCLES    = SAMPLE_CYCLES + CONVERT_CYCLES;
   localparam int CLK_PERIOD_NS   = 8;
   // ----------------------------------------------------------------
   // Input source and reference routing codes (mux select toward the analog side)
   // ----------------------------------------------------------------
   localparam logic [3:0] ROUTE_EXT      = 4'h0;
   localparam logic [3:0] ROUTE_AVDD     = 4'h1;
   localparam logic [3:0] ROUTE_AVDD_2   = 4'h2;
   localparam logic [3:0] ROUTE_AVDD_4   = 4'h3;
   localparam logic [3:0] ROUTE_PGA      = 4'h5;
   localparam logic [3:0] ROUTE_PGA_2    = 4'h6;
   localparam logic [3:0] ROUTE_PGA_4    = 4'h7;
   localparam logic [3:0] ROUTE_REG_DIV  = 4'h8;
   localparam logic [3:0] ROUTE_GROUND   = 4'h9;
   localparam logic [1:0] REF_SUPPLY     = 2'h0;
   localparam logic [1:0] REF_EXT_PIN    = 2'h1;
   localparam logic [1:0] REF_PGA_OUT    = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_SAMPLE  = 2'b10,
      ST_CONVERT = 2'b11
   } conv_state_t;
endpackage : adc_ctrl_pkg

// file: adc_input_reference_control.sv
// Converter control block: registers, start sequencing, busy flag, routing and clock divider
//
// Behaviour
// - Bit 6 of reference/gain register is not implemented and reads zero.
// - pga_input_select 0 routes external pin, 1 bandgap; bandgap cuts the pin.
// - Reference select 00 supply, 01 external pin, 1x PGA output.
// - Supply or PGA reference selection disconnects external reference pin.
// - PGA gain equals gain field plus one.
// - Start bit low-high-low: high resets converter, falling edge launches conversion.
// - Busy flag set by hardware once conversion is initiated, held meanwhile.
// - Busy flag cleared at conversion completion.
// - Conversion end sets interrupt request flag toward the interrupt controller.
// - Clock select divides system clock by two to the field value.
// - Sources 0000, 0100, 1100-1111 route the selected external channel.
// - Internal sources: supply fractions, PGA fractions, regulator divider, ground.
// - Channel 0000 pin zero, 0001 pin one, other values float.
// - Internal input selection disconnects every external analog channel.
// - Analog pin function disables other functions, pull-up, direction control.
// - Conversion lasts 4 sampling plus 12 converting converter clock cycles.
// - Alignment 0 puts D11-4 high, D3-0 low; 1 puts D11-8 high.
`timescale 1ns/100ps
`default_nettype none
module adc_input_reference_control
   import adc_ctrl_pkg::*;
#(
   parameter int RESULT_WIDTH = 12,
   parameter int PIN_COUNT    = 2
) (
   input  wire logic                    CLK,
   input  wire logic                    RST,
   input  wire logic [3:0]              ADDR,
   input  wire logic [7:0]              WDATA,
   input  wire logic                    WR,
   input  wire logic                    RD,
   output var  logic [7:0]              RDATA,
   input  wire logic [RESULT_WIDTH-1:0] CORE_RESULT,
   output var  logic                    CORE_RESET,
   output var  logic                    CORE_SAMPLE,
   output var  logic                    CORE_CONVERT,
   output var  logic                    CORE_POWER,
   output var  logic                    CONV_CLK_TICK,
   output var  logic [3:0]              INPUT_ROUTE,
   output var  logic [PIN_COUNT-1:0]    CHANNEL_CONNECT,
   output var  logic                    PGA_POWER,
   output var  logic [1:0]              PGA_GAIN,
   output var  logic                    PGA_EXT_PIN_CONNECT,
   output var  logic                    PGA_BANDGAP_CONNECT,
   output var  logic [1:0]              REF_ROUTE,
   output var  logic                    REF_EXT_PIN_CONNECT,
   output var  logic [PIN_COUNT-1:0]    PIN_ANALOG,
   output var  logic [PIN_COUNT-1:0]    PIN_PULLUP_DISABLE,
   output var  logic [PIN_COUNT-1:0]    PIN_DIRECTION_OVERRIDE,
   output var  logic                    IRQ_REQUEST
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Result byte packing below assumes a 12-bit core
   if (RESULT_WIDTH != 12) begin : g_bad_width
      $error("RESULT_WIDTH must be 12");
   end

   // The pin function register is eight bits wide
   if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_pins
      $error("PIN_COUNT must be 1 to 8");
   end

   // The cycle counter is four bits wide
   if (TOTAL_CYCLES > 16 || SAMPLE_CYCLES < 1) begin : g_bad_cycles
      $error("conversion cycle counts do not fit the counter");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      // Software-visible registers
      logic [7:0]              main_ctl;
      logic [7:0]              clk_in;
      logic [7:0]              ref_gain;
      logic [7:0]              pin_func;
      logic [RESULT_WIDTH-1:0] result;
      logic                    irq_flag;

      // Sequencer and divider
      logic                    start_prev;
      conv_state_t             state;
      logic [3:0]              cyc_cnt;
      logic [6:0]              div_cnt;
      logic                    tick;

      // Read data and core controls
      logic [7:0]              rdata;
      logic                    core_reset;
      logic                    core_sample;
      logic                    core_convert;

      // Analog switch controls
      logic [3:0]              input_route;
      logic [PIN_COUNT-1:0]    chan_connect;
      logic                    pga_ext;
      logic                    pga_bg;
      logic [1:0]              ref_route;
      logic                    ref_ext;
   } regs_t;

   regs_t r_r;
   regs_t r_nxt;

   // Decoded views of the stored registers
   logic       power_on;
   logic       start_bit;
   logic [6:0] div_last;
   logic       is_external;
   logic [3:0] src;
   logic [3:0] chan;

   // Result bytes as software reads them
   logic [7:0] hi_byte;
   logic [7:0] lo_byte;

   always_comb begin
      // ----------------------------------------------------------------
      // Decoded register fields
      // ----------------------------------------------------------------
      power_on  = r_r.main_ctl[MAIN_POWER_BIT];
      start_bit = r_r.main_ctl[MAIN_START_BIT];
      src       = r_r.clk_in[7:4];
      chan      = r_r.main_ctl[3:0];

      div_last  = 7'((8'h01 << r_r.clk_in[2:0]) - 8'h01);

      is_external = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);

      // ----------------------------------------------------------------
      // Result alignment
      // ----------------------------------------------------------------
      // result alignment
      if (r_r.main_ctl[MAIN_ALIGN_BIT]) begin
         hi_byte = {4'h0, r_r.result[11:8]};
         lo_byte = r_r.result[7:0];
      end else begin
         hi_byte = r_r.result[11:4];
         lo_byte = {4'h0, r_r.result[3:0]};
      end

      r_nxt       = r_r;
      r_nxt.rdata = RESET_BYTE;
      // Previous start level, for the falling-edge launch
      r_nxt.start_prev = start_bit;

      // ----------------------------------------------------------------
      // Converter clock divider
      // ----------------------------------------------------------------
      // Free-running while powered: the first converter cycle after a launch may be short
      // power-of-two divider, 000 passes every system clock
      if (r_r.div_cnt >= div_last || !power_on) begin
         r_nxt.div_cnt = 7'h00;
         r_nxt.tick    = power_on;
      end else begin
         r_nxt.div_cnt = r_r.div_cnt + 7'h01;
         r_nxt.tick    = 1'b0;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (WR) begin
         case (ADDR)
            // Busy bit is kept from the sequencer, so software cannot forge it
            OFS_MAIN_CONTROL: r_nxt.main_ctl = (WDATA & MAIN_WRITE_MASK)
                                              | (r_r.main_ctl & ~MAIN_WRITE_MASK);
            OFS_CLOCK_INPUT:  r_nxt.clk_in = WDATA & CLKIN_WRITE_MASK;
            OFS_REF_GAIN:     r_nxt.ref_gain = WDATA & REF_WRITE_MASK;
            OFS_PIN_FUNCTION: r_nxt.pin_func = WDATA;
            // Software clears the flag by writing one; a new end event wins below
            OFS_IRQ_FLAG: begin
               if (WDATA[0]) r_nxt.irq_flag = 1'b0;
            end
            // Unmapped offsets change nothing
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // Conversion sequencer
      // ----------------------------------------------------------------
      r_nxt.core_reset = 1'b0;

      // Dropping power abandons a conversion and leaves the stored result alone
      // power off aborts and holds busy low
      if (!power_on) begin
         r_nxt.state = ST_IDLE;
         r_nxt.cyc_cnt = 4'h0;
      end else begin
         case (r_r.state)
            ST_IDLE, ST_ARMED: begin
               // Holding start high keeps the core in reset and re-arms the launch
               // high level resets, falling edge launches
               if (start_bit) begin
                  r_nxt.core_reset = 1'b1;
                  r_nxt.state      = ST_ARMED;
               end else if (r_r.start_prev && r_r.state == ST_ARMED) begin
                  r_nxt.state   = ST_SAMPLE;
                  r_nxt.cyc_cnt = 4'h0;
               end
            end

            ST_SAMPLE, ST_CONVERT: begin
               if (start_bit) begin
                  r_nxt.core_reset = 1'b1;
                  r_nxt.state      = ST_ARMED;
               end else if (r_r.tick) begin
                  r_nxt.cyc_cnt = r_r.cyc_cnt + 4'h1;
                  // 4 sampling then 12 converting cycles
                  if (r_r.cyc_cnt == 4'(SAMPLE_CYCLES - 1)) begin
                     r_nxt.state = ST_CONVERT;
                  end
                  if (r_r.cyc_cnt == 4'(TOTAL_CYCLES - 1)) begin
                     r_nxt.state  = ST_IDLE;
                     // Taken at the last tick, while the core still drives a settled result
                     r_nxt.result = CORE_RESULT;
                     r_nxt.irq_flag = 1'b1;
                  end
               end
            end
            default: r_nxt.state = ST_IDLE;
         endcase
      end

      // busy flag shows conversion in progress
      r_nxt.main_ctl[MAIN_BUSY_BIT] = (r_nxt.state == ST_SAMPLE) || (r_nxt.state == ST_CONVERT);
      r_nxt.core_sample  = (r_nxt.state == ST_SAMPLE);
      r_nxt.core_convert = (r_nxt.state == ST_CONVERT);

      // ----------------------------------------------------------------
      // Analog routing
      // ----------------------------------------------------------------
      // Decoded from the stored source, so route and channel switches move in one cycle
      // internal source decode
      case (src)
         4'h1:    r_nxt.input_route = ROUTE_AVDD;
         4'h2:    r_nxt.input_route = ROUTE_AVDD_2;
         4'h3:    r_nxt.input_route = ROUTE_AVDD_4;
         4'h5:    r_nxt.input_route = ROUTE_PGA;
         4'h6:    r_nxt.input_route = ROUTE_PGA_2;
         4'h7:    r_nxt.input_route = ROUTE_PGA_4;
         4'h8:    r_nxt.input_route = ROUTE_REG_DIV;
         4'h9, 4'hA, 4'hB: r_nxt.input_route = ROUTE_GROUND;
         default: r_nxt.input_route = ROUTE_EXT;
      endcase

      // channel decode; internal source cuts all pins
      for (int i = 0; i < PIN_COUNT; i++) begin
         r_nxt.chan_connect[i] = is_external && (chan == 4'(i)) && (i < 2);
      end

      // bandgap choice cuts the external PGA pin
      r_nxt.pga_bg  = r_r.ref_gain[REF_PGA_IS_BIT];
      r_nxt.pga_ext = !r_r.ref_gain[REF_PGA_IS_BIT];

      // reference decode; only 01 connects external pin
      case (r_r.ref_gain[3:2])
         REF_SUPPLY:  r_nxt.ref_route = REF_SUPPLY;
         REF_EXT_PIN: r_nxt.ref_route = REF_EXT_PIN;
         default:     r_nxt.ref_route = REF_PGA_OUT;
      endcase
      r_nxt.ref_ext   = (r_r.ref_gain[3:2] == REF_EXT_PIN);

      // ----------------------------------------------------------------
      // Register reads, data one cycle later
      // ----------------------------------------------------------------
      // Idle cycles return zero, so several slaves may share one OR-ed read bus
      if (RD) begin
         case (ADDR)
            OFS_MAIN_CONTROL: r_nxt.rdata = r_r.main_ctl;
            OFS_CLOCK_INPUT:  r_nxt.rdata = r_r.clk_in;
            OFS_REF_GAIN:     r_nxt.rdata = r_r.ref_gain;
            OFS_RESULT_HIGH:  r_nxt.rdata = hi_byte;
            OFS_RESULT_LOW:   r_nxt.rdata = lo_byte;
            OFS_PIN_FUNCTION: r_nxt.rdata = r_r.pin_func;
            OFS_IRQ_FLAG:     r_nxt.rdata = {7'h00, r_r.irq_flag};
            default:          r_nxt.rdata = RESET_BYTE;
         endcase
      end
   end

   // The whole struct clears, then the idle code is set by name
   always_ff @(posedge CLK) begin
      if (RST) begin
         r_r       <= '0;
         r_r.state <= ST_IDLE;
      end else begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs straight from state flip-flops
   // ----------------------------------------------------------------
   assign RDATA               = r_r.rdata;
   assign CORE_RESET          = r_r.core_reset;
   assign CORE_SAMPLE         = r_r.core_sample;
   assign CORE_CONVERT        = r_r.core_convert;
   assign CORE_POWER          = r_r.main_ctl[MAIN_POWER_BIT];
   assign CONV_CLK_TICK       = r_r.tick;

   // ----------------------------------------------------------------
   // Converter input switches
   // ----------------------------------------------------------------
   assign INPUT_ROUTE         = r_r.input_route;
   assign CHANNEL_CONNECT     = r_r.chan_connect;

   // ----------------------------------------------------------------
   // PGA and reference switches
   // ----------------------------------------------------------------
   assign PGA_POWER           = r_r.ref_gain[REF_PGA_EN_BIT];
   // gain is field plus one on the analog side
   assign PGA_GAIN            = r_r.ref_gain[1:0];
   assign PGA_EXT_PIN_CONNECT = r_r.pga_ext;
   assign PGA_BANDGAP_CONNECT = r_r.pga_bg;
   assign REF_ROUTE           = r_r.ref_route;
   assign REF_EXT_PIN_CONNECT = r_r.ref_ext;

   // ----------------------------------------------------------------
   // Pin control and request
   // ----------------------------------------------------------------
   // analog pin overrides pull-up, direction and other functions
   assign PIN_ANALOG             = r_r.pin_func[PIN_COUNT-1:0];
   assign PIN_PULLUP_DISABLE     = r_r.pin_func[PIN_COUNT-1:0];
   assign PIN_DIRECTION_OVERRIDE = r_r.pin_func[PIN_COUNT-1:0];
   assign IRQ_REQUEST         = r_r.irq_flag;
endmodule // adc_input_reference_control
`default_nettype wire

// file: adc_irc_asserts.sv
// Port checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_irc_asserts
   import adc_ctrl_pkg::*;
#(
   parameter int PIN_COUNT = 2
) (
   input wire logic                 CLK,
   input wire logic                 RST,
   input wire logic                 RD,
   input wire logic [7:0]           RDATA,
   input wire logic                 CORE_SAMPLE,
   input wire logic                 CORE_CONVERT,
   input wire logic                 CORE_POWER,
   input wire logic                 CONV_CLK_TICK,
   input wire logic [3:0]           INPUT_ROUTE,
   input wire logic [PIN_COUNT-1:0] CHANNEL_CONNECT,
   input wire logic                 PGA_EXT_PIN_CONNECT,
   input wire logic                 PGA_BANDGAP_CONNECT,
   input wire logic [1:0]           REF_ROUTE,
   input wire logic                 REF_EXT_PIN_CONNECT,
   input wire logic [PIN_COUNT-1:0] PIN_ANALOG,
   input wire logic [PIN_COUNT-1:0] PIN_PULLUP_DISABLE,
   input wire logic [PIN_COUNT-1:0] PIN_DIRECTION_OVERRIDE,
   input wire logic                 IRQ_REQUEST
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_ref_ext; REF_EXT_PIN_CONNECT == (REF_ROUTE == REF_EXT_PIN); endproperty
   a_ref_ext: assert property (p_ref_ext) else $error("reference pin switch wrong");
   // Switch pair settles one cycle after reset release
   property p_pga_in; !$past(RST) && !$past(RST, 2) |-> PGA_EXT_PIN_CONNECT != PGA_BANDGAP_CONNECT;
   endproperty
   a_pga_in: assert property (p_pga_in) else $error("PGA input switches not complementary");
   property p_chan_int; INPUT_ROUTE != ROUTE_EXT |-> CHANNEL_CONNECT == '0; endproperty
   a_chan_int: assert property (p_chan_int) else $error("channel on with internal source");
   property p_chan_one; $onehot0(CHANNEL_CONNECT); endproperty
   a_chan_one: assert property (p_chan_one) else $error("two channels connected");
   property p_pins; PIN_PULLUP_DISABLE == PIN_ANALOG && PIN_DIRECTION_OVERRIDE == PIN_ANALOG;
   endproperty
   a_pins: assert property (p_pins) else $error("analog pin controls disagree");
   property p_off; !CORE_POWER && !$past(CORE_POWER) |-> !(CORE_SAMPLE || CORE_CONVERT || CONV_CLK_TICK);
   endproperty
   a_off: assert property (p_off) else $error("converter active while off");
   property p_seq; $fell(CORE_SAMPLE) && CORE_POWER |-> CORE_CONVERT; endproperty
   a_seq: assert property (p_seq) else $error("conversion did not follow sampling");
   property p_conv_min; $rose(CORE_CONVERT) |-> CORE_CONVERT [*8]; endproperty
   a_conv_min: assert property (p_conv_min) else $error("conversion phase too short");
   property p_irq; $rose(IRQ_REQUEST) |-> $past(CORE_CONVERT) || $past(CORE_CONVERT, 2); endproperty
   a_irq: assert property (p_irq) else $error("request flag without conversion end");
endmodule // adc_irc_asserts
`default_nettype wire

// file: adc_core_model.sv
// Behavioural model of the sample-convert core result lines
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
   input  wire logic        CLK,
   input  wire logic        CORE_CONVERT,
   input  wire logic [11:0] value,
   output var  logic [11:0] CORE_RESULT
);
   logic conv_d = 1'b0;
   logic flip   = 1'b0;
   always @(posedge CLK) begin
      conv_d <= CORE_CONVERT;
      flip   <= !flip;
   end
   // Outside a conversion and the cycle after it the lines churn, so a capture at the wrong moment shows
   assign CORE_RESULT = (CORE_CONVERT || conv_d) ? value : ~value ^ {12{flip}};
endmodule // adc_core_model
`default_nettype wire

// file: adc_input_reference_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_input_reference_control_tb_top;
   import adc_ctrl_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr = 4'h0, route;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [11:0] value = 12'h000, result;
   logic [1:0]  chan, pga_gain, ref_route, pin_an, pin_pu, pin_dir;
   logic        core_reset, core_sample, core_convert, core_power, tick;
   logic        pga_pwr, pga_ext, pga_bg, ref_ext, irq;
   int          err_total = 0, check_count = 0;
   adc_input_reference_control u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .CORE_RESULT(result), .CORE_RESET(core_reset),
      .CORE_SAMPLE(core_sample), .CORE_CONVERT(core_convert), .CORE_POWER(core_power),
      .CONV_CLK_TICK(tick), .INPUT_ROUTE(route), .CHANNEL_CONNECT(chan), .PGA_POWER(pga_pwr),
      .PGA_GAIN(pga_gain), .PGA_EXT_PIN_CONNECT(pga_ext), .PGA_BANDGAP_CONNECT(pga_bg),
      .REF_ROUTE(ref_route), .REF_EXT_PIN_CONNECT(ref_ext), .PIN_ANALOG(pin_an),
      .PIN_PULLUP_DISABLE(pin_pu), .PIN_DIRECTION_OVERRIDE(pin_dir), .IRQ_REQUEST(irq));
   adc_core_model u_core (.CLK(clk), .CORE_CONVERT(core_convert), .value(value),
      .CORE_RESULT(result));
   initial forever #4 clk = ~clk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task stop_test();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task t_regs();
      logic [7:0] d;
      for (int a = 0; a < 16; a++) begin
         rd_reg(a[3:0], d);
         chk(d, 16'h0000);
      end
      wr_reg(4'hF, 8'hFF);
      rd_reg(4'hF, d);
      chk(d, 16'h0000);
      wr_reg(OFS_REF_GAIN, 8'hDF);
      rd_reg(OFS_REF_GAIN, d);
      chk(d, 16'h009F);
      $display("t_regs done");
   endtask
   task t_ref();
      logic [4:0] i;
      for (int k = 0; k < 32; k++) begin
         i = k[4:0];
         // bandgap enable lives outside, taken as on
         // Reserved bit kept at zero by software
         wr_reg(OFS_REF_GAIN, {i[4], 2'b00, i[4], i[3:0]});
         settle();
         chk({pga_pwr, pga_bg, pga_ext, pga_gain}, {i[4], i[4], !i[4], i[1:0]});
         chk({ref_route, ref_ext}, {i[3] ? REF_PGA_OUT : i[3:2], i[3:2] == 2'b01});
      end
      $display("t_ref done");
   endtask
   task t_route();
      logic ext;
      for (int s = 0; s < 16; s++) begin
         for (int c = 0; c < 3; c++) begin
            ext = (s == 0 || s == 4 || s >= 12);
            wr_reg(OFS_CLOCK_INPUT, {s[3:0], 4'h0});
            wr_reg(OFS_MAIN_CONTROL, {4'h0, c[3:0]});
            settle();
            chk(route, ext ? ROUTE_EXT : (s > 8 ? ROUTE_GROUND : s[3:0]));
            chk(chan, (ext && c < 2) ? 2'b01 << c : 2'b00);
         end
      end
      for (int p = 1; p < 4; p++) begin
         wr_reg(OFS_PIN_FUNCTION, {6'h00, p[1:0]});
         settle();
         chk({pin_an, pin_pu, pin_dir}, {3{p[1:0]}});
      end
      $display("t_route done");
   endtask
   task t_conv(input logic [2:0] div, input logic al, input logic probe);
      logic [7:0] d, d2;
      int n, ns, nt, k, f, l;
      value = 12'hA5C ^ {9'h000, div};
      wr_reg(OFS_CLOCK_INPUT, {5'h00, div});
      wr_reg(OFS_MAIN_CONTROL, {3'b001, al, 4'h0});
      repeat (20) @(posedge clk);
      wr_reg(OFS_MAIN_CONTROL, {3'b101, al, 4'h0});
      @(posedge clk);
      #1 chk({core_reset, core_power}, 2'b11);
      wr_reg(OFS_MAIN_CONTROL, {3'b001, al, 4'h0});
      if (probe) begin
         repeat (100) @(posedge clk);
         rd_reg(OFS_MAIN_CONTROL, d);
         chk(d[MAIN_BUSY_BIT], 1'b1);
      end
      n = 0; ns = 0; nt = 0; k = 0; f = 0; l = 0;
      while (k < 5000 && !((n > 0 || probe) && !core_sample && !core_convert)) begin
         @(posedge clk);
         #1 n += (core_sample || core_convert);
         // The divider runs free, so converter cycles are counted by the ticks used
         if ((core_sample || core_convert) && tick) begin
            if (nt == 0) f = k;
            l = k;
            nt++;
            ns += core_sample;
         end
         k++;
      end
      if (k == 5000) begin
         err_total++;
         stop_test();
      end
      if (!probe) chk(nt, TOTAL_CYCLES);
      if (!probe) chk(ns, SAMPLE_CYCLES);
      if (!probe) chk(l - f, (TOTAL_CYCLES - 1) << div);
      rd_reg(OFS_MAIN_CONTROL, d);
      chk(d[MAIN_BUSY_BIT], 1'b0);
      chk(irq, 1'b1);
      rd_reg(OFS_RESULT_HIGH, d);
      rd_reg(OFS_RESULT_LOW, d2);
      if (al) chk({d, d2}, {4'h0, value});
      else chk({d, d2}, {value[11:4], 4'h0, value[3:0]});
      wr_reg(OFS_IRQ_FLAG, 8'h01);
      settle();
      chk(irq, 1'b0);
      $display("t_conv done");
   endtask
   task t_off();
      logic [7:0] d, old;
      logic seen;
      old = value[7:0];
      value = ~value;
      seen = 1'b0;
      wr_reg(OFS_MAIN_CONTROL, 8'h10);
      wr_reg(OFS_MAIN_CONTROL, 8'h90);
      wr_reg(OFS_MAIN_CONTROL, 8'h10);
      repeat (40) begin
         @(posedge clk);
         #1 seen |= core_sample | core_convert | core_reset;
      end
      chk(seen, 1'b0);
      rd_reg(OFS_MAIN_CONTROL, d);
      chk(d[MAIN_BUSY_BIT], 1'b0);
      rd_reg(OFS_RESULT_LOW, d);
      chk(d, old);
      $display("t_off done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_ref();
      t_route();
      t_conv(3'd0, 1'b1, 1'b0);
      t_conv(3'd2, 1'b0, 1'b0);
      t_conv(3'd7, 1'b1, 1'b1);
      t_off();
      stop_test();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule // adc_input_reference_control_tb_top
bind adc_input_reference_control adc_irc_asserts #(.PIN_COUNT(PIN_COUNT)) u_chk (.CLK(CLK),
   .RST(RST), .RD(RD), .RDATA(RDATA), .CORE_SAMPLE(CORE_SAMPLE), .CORE_CONVERT(CORE_CONVERT),
   .CORE_POWER(CORE_POWER), .CONV_CLK_TICK(CONV_CLK_TICK), .INPUT_ROUTE(INPUT_ROUTE),
   .CHANNEL_CONNECT(CHANNEL_CONNECT), .PGA_EXT_PIN_CONNECT(PGA_EXT_PIN_CONNECT),
   .PGA_BANDGAP_CONNECT(PGA_BANDGAP_CONNECT), .REF_ROUTE(REF_ROUTE),
   .REF_EXT_PIN_CONNECT(REF_EXT_PIN_CONNECT), .PIN_ANALOG(PIN_ANALOG),
   .PIN_PULLUP_DISABLE(PIN_PULLUP_DISABLE), .PIN_DIRECTION_OVERRIDE(PIN_DIRECTION_OVERRIDE),
   .IRQ_REQUEST(IRQ_REQUEST));
`default_nettype wire
